//--- src/tlvi_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion from the controller package and modules only
`ifndef TLVI_DEFS_SVH
`define TLVI_DEFS_SVH
`define TLVI_MASK_ADDR 8'hA8
`define TLVI_MASK_RESET 8'h00
`define TLVI_GATE_BIT 7
`define TLVI_NSRC 18
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008
`define TLVI_RESET_VEC 16'h0000
`define TLVI_DETECT_CYC 1
`define TLVI_CALL_CYC 4
`endif

//--- src/tlvi_pkg.sv
// Types shared by the vectored interrupt controller
// Assumes tlvi_defs.svh is on the include path
`include "tlvi_defs.svh"
package tlvi_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CALL = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_HOLD = 4'b1000
  } tlvi_state_t;

  // Special-function register access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlvi_sfr_t;

  // Call request presented to the core
  typedef struct packed {
    logic req;
    logic [15:0] vector;
  } tlvi_call_t;
endpackage

//--- src/tlvi_arbiter.sv
// Priority decoder: picks the winning enabled source
// Assumes requests are already gated by enables
`timescale 1ns/1ps
`default_nettype none
`include "tlvi_defs.svh"
module tlvi_arbiter #(
  parameter int NSRC = `TLVI_NSRC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [NSRC-1:0] active_i,
  input wire logic [NSRC-1:0] level_i,
  output logic valid_o,
  output logic high_o,
  output logic [4:0] index_o
);
  import tlvi_pkg::*;

  typedef struct packed {
    logic valid;
    logic high;
    logic [4:0] index;
  } tlvi_arb_t;

  tlvi_arb_t st, next_st;

  // Lowest set bit of a request vector
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // High level first, then lowest order number; decoded every cycle
  always_comb begin
    logic [NSRC-1:0] hi;
    hi = active_i & level_i;
    next_st.valid = |active_i;
    next_st.high = |hi;
    next_st.index = (|hi) ? first_set(hi) : first_set(active_i);
  end

  // Registered result costs the one detection cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign valid_o = st.valid;
  assign high_o = st.high;
  assign index_o = st.index;
endmodule
`default_nettype wire

//--- src/tlvi_ctrl.sv
// Two-level vectored interrupt controller, top level
// Assumes the core runs the call and signals ack, return and instruction end
// How it works
// - Each source has its own level bit; low after reset.
// - High may preempt low service; nothing preempts high service.
// - Higher level wins, then lowest order number 0 to 17.
// - Pending requests are sampled and decoded every clock.
// - Fastest answer: one detect cycle then four call cycles.
// - After a return, one more instruction runs before the call.
// - Worst case 18 clocks: detect, return, divide, call.
// - Equal or higher service in progress defers a new request.
// - Reset vector 0x0000; order n vectors to 0x0003 plus 8n.
// - Vectoring clears pin 0, pin 1, timer 0, timer 1, CAN flags.
// - Any of a source's several flags raises its one request.
// - Global gate bit 7 blocks all; set, each mask applies.
// - Mask bits 6..0: sync serial, timer2, serial, t1, pin1, t0, pin0.
// - Mask register at 0xA8, bit addressable, read-write, resets 0.
// - Priority bit per source from base or extended priority registers.
// - Flags set on their condition even while disabled.
// - A flag still set after return re-requests after one instruction.
// - Software-set flags request like hardware-set ones, but one set in the ack cycle of a hardware-cleared source is lost.
`timescale 1ns/1ps
`default_nettype none
`include "tlvi_defs.svh"
module tlvi_ctrl #(
  parameter int NSRC = `TLVI_NSRC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire tlvi_pkg::tlvi_sfr_t sfr_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic [NSRC-1:0] flag_set_i,
  input wire logic [NSRC-1:0] flag_sw_set_i,
  input wire logic [NSRC-1:0] flag_sw_clr_i,
  input wire logic [NSRC-1:0] ext_mask_i,
  input wire logic [NSRC-1:0] level_i,
  input wire logic call_ack_i,
  input wire logic return_from_handler_i,
  input wire logic instr_done_i,
  output tlvi_pkg::tlvi_call_t call_o,
  output logic [7:0] core_source_enable_mask_o,
  output logic [NSRC-1:0] pending_o,
  output logic [1:0] in_service_o
);
  import tlvi_pkg::*;

  // Sources whose flag hardware clears on vectoring: pins, timers 0/1, CAN
  localparam logic [NSRC-1:0] HW_CLR = NSRC'(18'h1000F);

  typedef struct packed {
    tlvi_state_t fsm;
    logic [7:0] mask;
    logic [NSRC-1:0] pend;
    logic [1:0] insvc;     // [1] high level, [0] low level in service
    logic [2:0] cnt;
    logic req;
    logic [15:0] vec;
    logic [4:0] idx;
  } tlvi_st_t;

  tlvi_st_t st, next_st;
  logic [NSRC-1:0] enabled, active;
  logic arb_valid, arb_high;
  logic [4:0] arb_index;

  // Vector address of source order n
  function automatic logic [15:0] vec_of(input logic [4:0] n);
    return `TLVI_VEC_BASE + 16'(n) * `TLVI_VEC_STEP;
  endfunction

  // Per-source enable: core mask holds first seven, rest from extended regs
  always_comb begin
    enabled = ext_mask_i;
    enabled[6:0] = st.mask[6:0];
    if (!st.mask[`TLVI_GATE_BIT]) begin
      enabled = '0;
    end
    active = st.pend & enabled;
  end

  tlvi_arbiter #(.NSRC(NSRC)) u_arb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .active_i(active),
    .level_i(level_i),
    .valid_o(arb_valid),
    .high_o(arb_high),
    .index_o(arb_index)
  );

  // Next state of registers, flags and call sequencer
  always_comb begin
    logic can_take;
    can_take = 1'b0;
    next_st = st;
    // Flags set regardless of enable; set wins over clear
    next_st.pend = (st.pend & ~flag_sw_clr_i) | flag_set_i
      | flag_sw_set_i;
    // Byte and bit writes to the mask register
    if (sfr_i.wr && sfr_i.addr == `TLVI_MASK_ADDR) begin
      next_st.mask = sfr_i.wdata;
    end else if (sfr_bit_wr_i && sfr_i.addr == `TLVI_MASK_ADDR) begin
      next_st.mask[sfr_bit_sel_i] = sfr_i.wdata[0];
    end
    // Only high may preempt low; high blocks everything
    can_take = arb_valid && !st.insvc[1]
      && (!st.insvc[0] || arb_high);
    next_st.req = 1'b0;
    unique case (st.fsm)
      ST_IDLE: begin
        if (can_take && active[arb_index]) begin
          next_st.req = 1'b1;
          next_st.vec = vec_of(arb_index);
          next_st.idx = arb_index;
          next_st.fsm = ST_CALL;
        end
      end
      ST_CALL: begin
        next_st.req = 1'b1;
        if (call_ack_i) begin
          next_st.req = 1'b0;
          next_st.cnt = 3'(`TLVI_CALL_CYC - 1);
          if (arb_high && level_i[st.idx]) begin
            next_st.insvc[1] = 1'b1;
          end else begin
            next_st.insvc[0] = 1'b1;
          end
          if (HW_CLR[st.idx] && !flag_set_i[st.idx]) begin
            next_st.pend[st.idx] = 1'b0;
          end
          next_st.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Call sequence runs in the core; hold off new decisions
        if (st.cnt == 3'h0) begin
          next_st.fsm = ST_IDLE;
        end else begin
          next_st.cnt = st.cnt - 3'h1;
        end
      end
      ST_HOLD: begin
        // One instruction must finish after a return
        if (instr_done_i) begin
          next_st.fsm = ST_IDLE;
        end
      end
    endcase
    // Return ends the innermost service level
    if (return_from_handler_i) begin
      if (st.insvc[1]) begin
        next_st.insvc[1] = 1'b0;
      end else begin
        next_st.insvc[0] = 1'b0;
      end
      if (st.fsm == ST_IDLE) begin
        next_st.req = 1'b0;
        next_st.fsm = ST_HOLD;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{fsm: ST_IDLE, mask: `TLVI_MASK_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign call_o.req = st.req;
  assign call_o.vector = st.vec;
  assign core_source_enable_mask_o = st.mask;
  assign pending_o = st.pend;
  assign in_service_o = st.insvc;

  // No request while the global gate is off
  gate_blocks_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($rose(st.req) && st.fsm == ST_CALL) |-> $past(st.mask[7], 2))
    else $error("call raised with gate off");
  // Vector matches its source order
  vector_map_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st.req |-> st.vec == 16'h0003 + 16'(st.idx) * 16'h0008)
    else $error("vector does not match source");
  // High service is never preempted
  high_nopreempt_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) (st.insvc[1] && st.fsm == ST_IDLE
    && !return_from_handler_i) |=> !st.req)
    else $error("high handler preempted");
  // After return the sequencer waits for one instruction
  return_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (return_from_handler_i && st.fsm == ST_IDLE) |=> st.fsm == ST_HOLD
    ##0 !st.req)
    else $error("no hold after return");
  // Set wins over a software clear
  flag_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (flag_set_i != '0) |=> ((st.pend & $past(flag_set_i))
    == $past(flag_set_i)))
    else $error("flag event lost");
  // Mask register write lands
  mask_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sfr_i.wr && sfr_i.addr == 8'hA8) |=> st.mask == $past(sfr_i.wdata))
    else $error("mask write lost");
  // Call phase holds four cycles after ack
  call_window_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st.fsm == ST_CALL && call_ack_i) |=> (st.fsm == ST_WAIT)[*4]
    ##1 st.fsm != ST_WAIT)
    else $error("call window length wrong");
  // Pin 0 hardware-cleared flag drops on ack
  hw_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st.fsm == ST_CALL && call_ack_i && st.idx == 5'h00
    && !flag_set_i[0]) |=> !st.pend[0])
    else $error("pin 0 flag not cleared");
endmodule
`default_nettype wire

//--- tb/tlvi_core_model.sv
// Core sequencer model: acks calls, runs a return then a divide
// Assumes the controller's call struct and a bench return command
`timescale 1ns/1ps
`default_nettype none
module tlvi_core_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire tlvi_pkg::tlvi_call_t call_i,
  input wire logic [1:0] dly_i,
  input wire logic ret_cmd_i,
  output logic ack_o,
  output logic ret_o,
  output logic done_o
);
  logic [1:0] cnt;
  logic [3:0] left;
  logic asked;
  assign asked = call_i.req && !ack_o;
  // Ack only while a call is asked, after a chosen delay
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 2'h0;
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      left <= 4'h0;
      done_o <= 1'b0;
    end else begin
      ack_o <= asked && cnt == dly_i;
      cnt <= (asked && cnt != dly_i) ? cnt + 2'h1 : 2'h0;
      ret_o <= ret_cmd_i;
      left <= ret_cmd_i ? 4'hD : (left != 4'h0 ? left - 4'h1 : 4'h0);
      done_o <= left == 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/two_level_vectored_interrupt_ctrl_test.sv
// Bench: drives registers and flags, checks each vector call taken
// Assumes the core model answers calls and returns on command
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_interrupt_ctrl_test;
  import tlvi_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i;
  tlvi_sfr_t sfr;
  logic bwr;
  logic [2:0] bsel;
  logic [17:0] hset, sset, sclr, emask, lvl;
  logic ack, retp, done;
  logic rcmd;
  logic [1:0] dly;
  tlvi_call_t call;
  logic [7:0] mask;
  logic [17:0] pend;
  logic [1:0] insvc;
  logic [17:0] q[$];
  int n_fail = 0;
  int checked = 0;
  logic [15:0] rnd = 16'd20399;
  tlvi_ctrl u_tlvi_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_i(sfr),
    .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .flag_set_i(hset),
    .flag_sw_set_i(sset), .flag_sw_clr_i(sclr), .ext_mask_i(emask),
    .level_i(lvl), .call_ack_i(ack), .return_from_handler_i(retp),
    .instr_done_i(done), .call_o(call), .core_source_enable_mask_o(mask),
    .pending_o(pend), .in_service_o(insvc));
  tlvi_core_model u_tlvi_core_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .call_i(call), .dly_i(dly), .ret_cmd_i(rcmd), .ack_o(ack),
    .ret_o(retp), .done_o(done));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    sfr = {1'b1, 8'hA8, d};
    tick(1);
    sfr = '0;
  endtask
  task automatic raise(input logic [17:0] f);
    sset = f;
    tick(1);
    sset = '0;
  endtask
  // Wait for every noted call to be taken, then flag leftovers
  task automatic drain();
    for (int i = 0; i < 60 && q.size() != 0; i++) tick(1);
    chk(18'(q.size()), 18'h0);
    q.delete();
  endtask
  // Clear chosen flags and run return plus one long instruction
  task automatic leave(input logic [17:0] clr);
    sclr = clr;
    rcmd = 1'b1;
    tick(1);
    sclr = '0;
    rcmd = 1'b0;
    tick(16);
  endtask
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Each accepted call takes the oldest note off the queue
  always @(posedge mclk_i) begin
    if (call.req === 1'b1 && ack === 1'b1) begin
      chk(q.size() ? q.pop_front() : 18'h3FFFF, 18'(call.vector));
    end
  end
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    sfr = '0;
    bwr = 1'b0;
    bsel = 3'h0;
    hset = '0;
    sset = '0;
    sclr = '0;
    emask = '1;
    lvl = '0;
    rcmd = 1'b0;
    dly = 2'h0;
    tick(2);
    rst_n_i = 1'b1;
    tick(1);
    chk(18'(mask), 18'h0);
    chk(pend, 18'h0);
    wr(8'h82);
    chk(18'(mask), 18'h82);
    q.push_back(18'h0B);
    raise(18'h2);
    drain();
    tick(1);
    chk(18'(pend[1]), 18'h0);
    chk(18'(insvc), 18'h1);
    leave('1);
    // Gate low: flag sets but no call until the gate bit is written
    wr(8'h02);
    hset = 18'h2;
    tick(1);
    hset = '0;
    tick(6);
    chk(18'(pend[1]), 18'h1);
    q.push_back(18'h0B);
    sfr = {1'b0, 8'hA8, 8'h01};
    bsel = 3'h7;
    bwr = 1'b1;
    tick(1);
    bwr = 1'b0;
    sfr = '0;
    drain();
    chk(18'(mask), 18'h82);
    leave('1);
    // Every source in turn, random ack delay and level
    wr(8'hFF);
    for (int n = 0; n < 18; n++) begin
      rnd = lfsr(rnd);
      dly = rnd[1:0];
      lvl = {18{rnd[2]}};
      // Random extended masks, with the source under test kept enabled
      emask = {rnd, rnd[1:0]} | (18'h1 << n);
      q.push_back(18'h3 + 18'(8 * n));
      raise(18'h1 << n);
      drain();
      chk(18'(pend[n]), (n < 4 || n == 16) ? 18'h0 : 18'h1);
      leave('1);
    end
    // Level first, then order; one instruction after each return
    emask = '1;
    lvl = 18'h200;
    q.push_back(18'h4B);
    raise(18'h228);
    drain();
    q.push_back(18'h1B);
    leave(18'h200);
    drain();
    q.push_back(18'h2B);
    leave(18'h0);
    drain();
    leave('1);
    // High preempts low; nothing enters during high or equal service
    q.push_back(18'h23);
    raise(18'h10);
    drain();
    q.push_back(18'h4B);
    raise(18'h200);
    drain();
    chk(18'(insvc), 18'h3);
    raise(18'h4);
    leave(18'h200);
    q.push_back(18'h13);
    leave(18'h10);
    drain();
    leave('1);
    // A flag left set re-enters after the return
    q.push_back(18'h23);
    raise(18'h10);
    drain();
    q.push_back(18'h23);
    leave(18'h0);
    drain();
    leave('1);
    wrap_up();
  end
endmodule
`default_nettype wire
